// ### usls_defines.vh
// register offsets, field positions, reset values and timing counts of the status block
`ifndef USLS_DEFINES_VH
`define USLS_DEFINES_VH
`define USLS_ADDR_RBR_THR 3'h0
`define USLS_ADDR_IER 3'h1
`define USLS_ADDR_IIR 3'h2
`define USLS_ADDR_LCR 3'h3
`define USLS_ADDR_LSR 3'h5
`define USLS_ADDR_MSR 3'h6
`define USLS_LSR_DR 0
`define USLS_LSR_OE 1
`define USLS_LSR_PE 2
`define USLS_LSR_FE 3
`define USLS_LSR_BI 4
`define USLS_LSR_TX_HOLDING_EMPTY 5
`define USLS_LSR_TX_ALL_EMPTY 6
`define USLS_LSR_BIT7 7
`define USLS_IER_RDA 0
`define USLS_IER_TX_HOLDING_EMPTY 1
`define USLS_IER_LS 2
`define USLS_IER_MS 3
`define USLS_LCR_STB 2
`define USLS_LCR_PEN 3
`define USLS_LCR_EPS 4
`define USLS_LCR_DLAB 7
`define USLS_IID_NONE 3'h1
`define USLS_IID_LS 3'h6
`define USLS_IID_RDA 3'h4
`define USLS_IID_TX_HOLDING_EMPTY 3'h2
`define USLS_IID_MS 3'h0
`define USLS_RST_IER 8'h00
`define USLS_RST_LCR 8'h00
`define USLS_RST_DIV 16'h0000
`define USLS_RST_DLL 8'h00
`define USLS_RST_DLM 8'h00
`define USLS_OVERSAMPLE 12'h010
`define USLS_HALF_BIT 12'h008
`define USLS_MIN_BITS 12'h006
`endif

// ### usls_baud_gen.v
// programmable divider producing the sixteen-times bit clock tick
`include "usls_defines.vh"
module usls_baud_gen (
  input wire mclk, // reference clock
  input wire sys_rst, // synchronous reset, active high
  input wire [15:0] divisor, // programmed divisor, zero stops the tick
  input wire load, // pulse: a divisor byte was written
  output reg tick16 // one-cycle pulse at sixteen times the bit rate
);
  reg [15:0] count_reg;
  always @(posedge mclk) begin
    if (sys_rst) begin
      count_reg <= `USLS_RST_DIV;
      tick16 <= 1'b0;
    end else if (load) begin
      // reload at once so a new divisor never waits out an old long count
      count_reg <= divisor;
      tick16 <= 1'b0;
    end else if (divisor == 16'h0000) begin
      tick16 <= 1'b0;
    end else if (count_reg <= 16'h0001) begin
      count_reg <= divisor;
      tick16 <= 1'b1;
    end else begin
      count_reg <= count_reg - 16'h0001;
      tick16 <= 1'b0;
    end
  end
endmodule

// ### usls_buf2.v
// two-entry buffer with valid and ready on both sides
module usls_buf2 (
  input wire mclk, // clock
  input wire sys_rst, // synchronous reset, active high
  input wire in_valid, // word offered
  output wire in_ready, // room for a word
  input wire [7:0] in_data, // offered word
  output wire out_valid, // word available
  input wire out_ready, // drain side takes the word
  output wire [7:0] out_data // oldest word
);
  reg [7:0] mem_reg [0:1];
  reg wr_ptr_reg;
  reg rd_ptr_reg;
  reg [1:0] fill_reg;
  wire push;
  wire pop;
  assign in_ready = (fill_reg != 2'h2);
  assign out_valid = (fill_reg != 2'h0);
  assign out_data = mem_reg[rd_ptr_reg];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  always @(posedge mclk) begin
    if (sys_rst) begin
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      fill_reg <= 2'h0;
      mem_reg[0] <= 8'h00;
      mem_reg[1] <= 8'h00;
    end else begin
      if (push) begin
        mem_reg[wr_ptr_reg] <= in_data;
        wr_ptr_reg <= ~wr_ptr_reg;
      end
      if (pop) begin
        rd_ptr_reg <= ~rd_ptr_reg;
      end
      if (push & ~pop) begin
        fill_reg <= fill_reg + 2'h1;
      end else if (pop & ~push) begin
        fill_reg <= fill_reg - 2'h1;
      end
    end
  end
endmodule

// ### usls_top.v
// line status, interrupt identification and register access of the serial element
`include "usls_defines.vh"
module usls_top (
  input wire mclk, // reference clock
  input wire sys_rst, // synchronous reset, active high
  input wire cs, // chip select for a register access
  input wire [2:0] addr, // register address
  input wire rd_stb, // one-cycle read strobe
  input wire wr_stb, // one-cycle write strobe
  input wire [7:0] wdata, // write data
  output reg [7:0] rdata, // read data, valid the cycle after rd_stb
  output wire intrpt, // interrupt request, active high
  output wire tick16, // sixteen-times bit clock pulse
  input wire rx_char_stb, // pulse: receiver finished a character
  input wire [7:0] rx_char, // received data bits, low bits used
  input wire rx_par_bit, // received parity bit
  input wire rx_stop_bit, // first stop bit as sampled
  input wire sin, // serial input level, for break detection
  output wire tx_valid, // character offered to the shifter
  input wire tx_ready, // shifter takes the character
  output wire [7:0] tx_data, // character for the shifter
  input wire tx_shift_busy, // shifter still holds a character
  input wire cts_n, // clear to send, active low
  input wire dsr_n, // data set ready, active low
  input wire ri_n, // ring indicator, active low
  input wire dcd_n, // carrier detect, active low
  output wire [5:0] lcr_out // word length, stop, parity and stick settings
);
  ////////////////////////////////////////////////////////////////////////////
  reg [7:0] rbr_reg;
  reg [7:0] thr_reg;
  reg [7:0] ier_reg;
  reg [7:0] lcr_reg;
  reg [7:0] dll_reg;
  reg [7:0] dlm_reg;
  reg wr_div_reg;
  reg dr_reg;
  reg oe_reg;
  reg pe_reg;
  reg fe_reg;
  reg bi_reg;
  reg tx_holding_empty_reg;
  reg tx_holding_empty_int_reg;
  reg [3:0] msr_delta_reg;
  reg [3:0] modem_prev_reg;
  reg [11:0] low_cnt_reg;
  reg brk_seen_reg;
  reg [2:0] iid_reg;
  reg [2:0] iid_next;
  wire dlab;
  wire acc_rd;
  wire acc_wr;
  wire rd_rbr;
  wire rd_iir;
  wire rd_lsr;
  wire rd_msr;
  wire wr_thr;
  wire wr_div;
  wire thr_move;
  wire buf_in_ready;
  wire par_calc;
  wire par_err;
  wire [7:0] lsr_val;
  wire [7:0] msr_val;
  wire [3:0] modem_now;
  wire [3:0] modem_chg;
  wire [11:0] char_ticks;
  wire [11:0] stop_ticks;
  wire [11:0] data_ticks;
  wire [7:0] data_mask;
  wire ls_pend;
  wire rda_pend;
  wire tx_holding_empty_pend;
  wire ms_pend;
  wire tx_all_empty;
  ////////////////////////////////////////////////////////////////////////////
  // register access decode
  assign dlab = lcr_reg[`USLS_LCR_DLAB];
  assign acc_rd = cs & rd_stb;
  assign acc_wr = cs & wr_stb;
  assign rd_rbr = acc_rd & (addr == `USLS_ADDR_RBR_THR) & ~dlab;
  assign rd_iir = acc_rd & (addr == `USLS_ADDR_IIR);
  assign rd_lsr = acc_rd & (addr == `USLS_ADDR_LSR);
  assign rd_msr = acc_rd & (addr == `USLS_ADDR_MSR);
  assign wr_thr = acc_wr & (addr == `USLS_ADDR_RBR_THR) & ~dlab;
  assign wr_div = acc_wr & dlab & ((addr == `USLS_ADDR_RBR_THR) | (addr == `USLS_ADDR_IER));
  assign lcr_out = lcr_reg[5:0];
  ////////////////////////////////////////////////////////////////////////////
  // baud divider and transmit path buffer
  usls_baud_gen u_baud (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .divisor({dlm_reg, dll_reg}),
    .load(wr_div_reg),
    .tick16(tick16)
  );
  // holding register moves on only when the buffer has room
  assign thr_move = ~tx_holding_empty_reg & buf_in_ready;
  usls_buf2 u_txbuf (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .in_valid(~tx_holding_empty_reg),
    .in_ready(buf_in_ready),
    .in_data(thr_reg),
    .out_valid(tx_valid),
    .out_ready(tx_ready),
    .out_data(tx_data)
  );
  assign tx_all_empty = tx_holding_empty_reg & ~tx_valid & ~tx_shift_busy;
  ////////////////////////////////////////////////////////////////////////////
  // received character checks
  assign data_mask = 8'hff >> (3'h3 - {1'b0, lcr_reg[1:0]});
  assign par_calc = ^(rx_char & data_mask) ^ rx_par_bit;
  // even sense wants an even count of ones including the parity bit
  assign par_err = lcr_reg[`USLS_LCR_PEN] & (par_calc == lcr_reg[`USLS_LCR_EPS]);
  // character time in sixteenth-bit ticks: start, data, parity and stop
  assign data_ticks = (`USLS_MIN_BITS + {10'h000, lcr_reg[1:0]}) * `USLS_OVERSAMPLE;
  assign stop_ticks = ~lcr_reg[`USLS_LCR_STB] ? `USLS_OVERSAMPLE :
    (lcr_reg[1:0] == 2'h0) ? (`USLS_OVERSAMPLE + `USLS_HALF_BIT) :
    (`USLS_OVERSAMPLE + `USLS_OVERSAMPLE);
  assign char_ticks = data_ticks + stop_ticks +
    (lcr_reg[`USLS_LCR_PEN] ? `USLS_OVERSAMPLE : 12'h000);
  ////////////////////////////////////////////////////////////////////////////
  // modem lines, complemented, and their change flags
  assign modem_now = {~dcd_n, ~ri_n, ~dsr_n, ~cts_n};
  assign modem_chg[0] = modem_now[0] ^ modem_prev_reg[0];
  assign modem_chg[1] = modem_now[1] ^ modem_prev_reg[1];
  assign modem_chg[2] = modem_prev_reg[2] & ~modem_now[2];
  assign modem_chg[3] = modem_now[3] ^ modem_prev_reg[3];
  assign msr_val = {modem_now, msr_delta_reg};
  ////////////////////////////////////////////////////////////////////////////
  // line status flags; a setting event in the clearing cycle wins
  always @(posedge mclk) begin
    if (sys_rst) begin
      rbr_reg <= 8'h00;
      dr_reg <= 1'b0;
      oe_reg <= 1'b0;
      pe_reg <= 1'b0;
      fe_reg <= 1'b0;
    end else begin
      if (rx_char_stb) begin
        rbr_reg <= rx_char & data_mask;
        dr_reg <= 1'b1;
      end else if (rd_rbr) begin
        dr_reg <= 1'b0;
      end
      if (rx_char_stb & dr_reg & ~rd_rbr) begin
        oe_reg <= 1'b1;
      end else if (rd_lsr) begin
        oe_reg <= 1'b0;
      end
      if (rx_char_stb & par_err) begin
        pe_reg <= 1'b1;
      end else if (rd_lsr) begin
        pe_reg <= 1'b0;
      end
      if (rx_char_stb & ~rx_stop_bit) begin
        fe_reg <= 1'b1;
      end else if (rd_lsr) begin
        fe_reg <= 1'b0;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // break detection counts ticks of a continuous spacing level
  always @(posedge mclk) begin
    if (sys_rst) begin
      low_cnt_reg <= 12'h000;
      brk_seen_reg <= 1'b0;
      bi_reg <= 1'b0;
    end else begin
      if (sin) begin
        low_cnt_reg <= 12'h000;
        brk_seen_reg <= 1'b0;
      end else if (tick16 & ~brk_seen_reg) begin
        low_cnt_reg <= low_cnt_reg + 12'h001;
      end
      // flag once per spacing period, only after the full character time
      if (~sin & tick16 & ~brk_seen_reg & (low_cnt_reg >= char_ticks)) begin
        brk_seen_reg <= 1'b1;
        bi_reg <= 1'b1;
      end else if (rd_lsr) begin
        bi_reg <= 1'b0;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // holding register and its empty flags
  always @(posedge mclk) begin
    if (sys_rst) begin
      thr_reg <= 8'h00;
      tx_holding_empty_reg <= 1'b1;
      tx_holding_empty_int_reg <= 1'b1;
    end else begin
      if (wr_thr) begin
        // a write while still full and the buffer full replaces the waiting character
        thr_reg <= wdata;
        tx_holding_empty_reg <= 1'b0;
        tx_holding_empty_int_reg <= 1'b0;
      end else if (thr_move) begin
        tx_holding_empty_reg <= 1'b1;
        tx_holding_empty_int_reg <= 1'b1;
      end else if (rd_iir & (iid_reg == `USLS_IID_TX_HOLDING_EMPTY)) begin
        tx_holding_empty_int_reg <= 1'b0;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // control registers and modem change flags
  always @(posedge mclk) begin
    if (sys_rst) begin
      ier_reg <= `USLS_RST_IER;
      lcr_reg <= `USLS_RST_LCR;
      dll_reg <= `USLS_RST_DLL;
      dlm_reg <= `USLS_RST_DLM;
      msr_delta_reg <= 4'h0;
      modem_prev_reg <= 4'h0;
      wr_div_reg <= 1'b0;
    end else begin
      // reload one cycle later so the counter sees the byte just written
      wr_div_reg <= wr_div;
      if (acc_wr & (addr == `USLS_ADDR_RBR_THR) & dlab) begin
        dll_reg <= wdata;
      end
      if (acc_wr & (addr == `USLS_ADDR_IER) & dlab) begin
        dlm_reg <= wdata;
      end else if (acc_wr & (addr == `USLS_ADDR_IER)) begin
        ier_reg <= {4'h0, wdata[3:0]};
      end
      if (acc_wr & (addr == `USLS_ADDR_LCR)) begin
        lcr_reg <= wdata;
      end
      modem_prev_reg <= modem_now;
      if (rd_msr) begin
        msr_delta_reg <= modem_chg;
      end else begin
        msr_delta_reg <= msr_delta_reg | modem_chg;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // interrupt priority
  assign ls_pend = ier_reg[`USLS_IER_LS] & (oe_reg | pe_reg | fe_reg | bi_reg);
  assign rda_pend = ier_reg[`USLS_IER_RDA] & dr_reg;
  assign tx_holding_empty_pend = ier_reg[`USLS_IER_TX_HOLDING_EMPTY] & tx_holding_empty_int_reg;
  assign ms_pend = ier_reg[`USLS_IER_MS] & (|msr_delta_reg);
  always @* begin
    if (ls_pend) begin
      iid_next = `USLS_IID_LS;
    end else if (rda_pend) begin
      iid_next = `USLS_IID_RDA;
    end else if (tx_holding_empty_pend) begin
      iid_next = `USLS_IID_TX_HOLDING_EMPTY;
    end else if (ms_pend) begin
      iid_next = `USLS_IID_MS;
    end else begin
      iid_next = `USLS_IID_NONE;
    end
  end
  always @(posedge mclk) begin
    if (sys_rst) begin
      iid_reg <= `USLS_IID_NONE;
    end else if (~rd_iir) begin
      iid_reg <= iid_next;
    end
  end
  // the code seen by a read stays put for the whole access
  assign intrpt = ~iid_reg[0];
  ////////////////////////////////////////////////////////////////////////////
  // read data
  assign lsr_val = {1'b0, tx_all_empty, tx_holding_empty_reg, bi_reg, fe_reg, pe_reg, oe_reg, dr_reg};
  always @(posedge mclk) begin
    if (sys_rst) begin
      rdata <= 8'h00;
    end else if (acc_rd) begin
      if (addr == `USLS_ADDR_RBR_THR) begin
        rdata <= dlab ? dll_reg : rbr_reg;
      end else if (addr == `USLS_ADDR_IER) begin
        rdata <= dlab ? dlm_reg : ier_reg;
      end else if (addr == `USLS_ADDR_IIR) begin
        rdata <= {5'h00, iid_reg};
      end else if (addr == `USLS_ADDR_LCR) begin
        rdata <= lcr_reg;
      end else if (addr == `USLS_ADDR_LSR) begin
        rdata <= lsr_val;
      end else if (addr == `USLS_ADDR_MSR) begin
        rdata <= msr_val;
      end else begin
        rdata <= 8'h00;
      end
    end
  end
  // writes to the status register are ignored
endmodule

// ### usls_monitor.sv
// port checker for the line status and interrupt identification block
module usls_monitor (
  input wire logic mclk, // clock
  input wire logic sys_rst, // reset
  input wire logic cs, // select
  input wire logic [2:0] addr, // address
  input wire logic rd_stb, // read
  input wire logic wr_stb, // write
  input wire logic [7:0] wdata, // write data
  input wire logic [7:0] rdata, // read data
  input wire logic intrpt, // request
  input wire logic tick16, // tick
  input wire logic rx_char_stb, // rx done
  input wire logic [7:0] rx_char, // rx data
  input wire logic rx_par_bit, // parity
  input wire logic rx_stop_bit, // stop
  input wire logic sin, // line
  input wire logic tx_valid, // tx valid
  input wire logic tx_ready, // tx ready
  input wire logic [7:0] tx_data, // tx data
  input wire logic tx_shift_busy, // busy
  input wire logic cts_n, // cts
  input wire logic dsr_n, // dsr
  input wire logic ri_n, // ring
  input wire logic dcd_n, // carrier
  input wire logic [5:0] lcr_out // line control
);
  timeunit 1ns;
  timeprecision 1ps;
  wire rd_lsr = cs && rd_stb && addr == 3'h5;
  wire rd_iir = cs && rd_stb && addr == 3'h2;
  // line high and no character arriving, so no flag can set meanwhile
  wire calm = sin && !rx_char_stb;
  default clocking mon_cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////////////////////////////////////////////
  a_lsr_bit7_zero: assert property (rd_lsr |=> !rdata[7])
    else $error("status bit 7 set");
  a_tx_all_empty_needs_tx_holding_empty: assert property (rd_lsr |=> rdata[5] || !rdata[6])
    else $error("tx empty without holding empty");
  a_tx_all_empty_while_busy: assert property (tx_shift_busy ##1 tx_shift_busy && rd_lsr |=> !rdata[6])
    else $error("tx empty while shifting");
  a_err_flags_cleared: assert property (rd_lsr && calm ##1 calm ##1 rd_lsr && calm |=> rdata[4:1] == 4'h0)
    else $error("error flags survived a status read");
  a_iir_upper_zero: assert property (rd_iir |=> rdata[7:3] == 5'h00)
    else $error("id upper bits set");
  a_iir_pending_bit: assert property (rd_iir |=> rdata[0] == !intrpt)
    else $error("id bit 0 disagrees with request");
  a_iir_code_legal: assert property (rd_iir |=> !(rdata[0] && rdata[2:1] != 2'h0))
    else $error("illegal id code");
  a_tx_word_held: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("offered character lost");
  a_reset_quiet: assert property ($fell(sys_rst) |-> !intrpt && !tx_valid && rdata == 8'h00)
    else $error("outputs not quiet after reset");
  a_lcr_written: assert property (cs && wr_stb && addr == 3'h3 |=> lcr_out == $past(wdata[5:0]))
    else $error("line control not updated");
  c_overrun_seen: cover property (rd_lsr ##1 rdata[1]);
  c_irq_raised: cover property ($rose(intrpt));
  c_tx_stalled: cover property (tx_valid && !tx_ready);
endmodule
bind usls_top usls_monitor u_mon (.*);

// ### usls_shifter_model.sv
// transmit shifter model that takes characters and stays busy while sending them
module usls_shifter_model #(
  parameter int BUSY_CYCLES = 40
) (
  input wire logic mclk, // clock
  input wire logic sys_rst, // reset
  input wire logic tx_valid, // offered
  output logic tx_ready, // taking
  input wire logic [7:0] tx_data, // character
  output logic tx_shift_busy, // sending
  output logic [7:0] got_count, // taken count
  output logic [31:0] got_log // last four taken
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] busy_cnt;
  // only an idle shifter takes the next character, so the buffer must hold the rest
  assign tx_ready = busy_cnt == 8'h00;
  assign tx_shift_busy = busy_cnt != 8'h00;
  always @(posedge mclk) begin
    if (sys_rst) begin
      busy_cnt <= 8'h00;
      got_count <= 8'h00;
      got_log <= 32'h0;
    end else if (tx_valid && tx_ready) begin
      busy_cnt <= 8'(BUSY_CYCLES);
      got_count <= got_count + 8'h01;
      got_log <= {got_log[23:0], tx_data};
    end else if (busy_cnt != 8'h00) begin
      busy_cnt <= busy_cnt - 8'h01;
    end
  end
endmodule

// ### usls_top_tb.sv
// self-checking bench for the line status and interrupt identification block
module usls_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic cs = 1'b0, rd_stb = 1'b0, wr_stb = 1'b0, rx_char_stb = 1'b0, rx_par_bit = 1'b0;
  logic rx_stop_bit = 1'b1, sin = 1'b1, cts_n = 1'b1, dsr_n = 1'b1, ri_n = 1'b1, dcd_n = 1'b1;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00, rx_char = 8'h00;
  wire [7:0] rdata, tx_data, got_count;
  wire [31:0] got_log;
  wire [5:0] lcr_out;
  wire intrpt, tick16, tx_valid, tx_ready, tx_shift_busy;
  int fail_count = 0;
  int comparisons = 0;
  int n;
  logic [7:0] gap;
  // line control, character, expected status, parity bit at [4], stop bit at [0]
  logic [31:0] par_case [5] = '{32'h1b01_6501, 32'h1b01_6111, 32'h0b03_6501, 32'h0b03_6111,
    32'h035a_6910};
  always #5 mclk = ~mclk;
  usls_top u_dut (.*);
  usls_shifter_model u_shift (.*);
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick_gap(input logic [7:0] exp);
    n = 0;
    while (tick16 !== 1'b1 && n < 100) begin
      @(negedge mclk);
      n++;
    end
    gap = 8'h00;
    do begin
      @(negedge mclk);
      gap++;
    end while (tick16 !== 1'b1 && gap < 8'h64);
    chk_byte(gap, exp);
  endtask
  // the bench never writes the status register
  task automatic bus_wr(input logic [2:0] a, input logic [7:0] d);
    @(negedge mclk);
    cs = 1'b1;
    addr = a;
    wdata = d;
    wr_stb = 1'b1;
    @(negedge mclk);
    cs = 1'b0;
    wr_stb = 1'b0;
  endtask
  task automatic bus_rd(input logic [2:0] a, input logic [7:0] exp);
    @(negedge mclk);
    cs = 1'b1;
    addr = a;
    rd_stb = 1'b1;
    @(negedge mclk);
    cs = 1'b0;
    rd_stb = 1'b0;
    chk_byte(rdata, exp);
  endtask
  task automatic rx(input logic [7:0] ch, input logic par, input logic stp);
    @(negedge mclk);
    rx_char_stb = 1'b1;
    rx_char = ch;
    rx_par_bit = par;
    rx_stop_bit = stp;
    @(negedge mclk);
    rx_char_stb = 1'b0;
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #200us;
    fail_count++;
    $display("ERROR at %0t: watchdog expired", $time);
    report_and_stop();
  end
  initial begin
    repeat (20) @(negedge mclk);
    sys_rst = 1'b0;
    bus_rd(3'h6, 8'h00);
    bus_rd(3'h5, 8'h60);
    bus_rd(3'h2, 8'h01);
    bus_wr(3'h3, 8'h83);
    bus_wr(3'h0, 8'h14);
    bus_wr(3'h1, 8'h00);
    tick_gap(8'h14);
    bus_wr(3'h0, 8'h0c);
    bus_wr(3'h3, 8'h03);
    tick_gap(8'h0c);
    rx(8'h5a, 1'b0, 1'b1);
    bus_rd(3'h5, 8'h61);
    bus_rd(3'h0, 8'h5a);
    bus_rd(3'h5, 8'h60);
    rx(8'h11, 1'b0, 1'b1);
    rx(8'h22, 1'b0, 1'b1);
    bus_rd(3'h5, 8'h63);
    bus_rd(3'h5, 8'h61);
    bus_rd(3'h0, 8'h22);
    foreach (par_case[i]) begin
      bus_wr(3'h3, par_case[i][31:24]);
      rx(par_case[i][23:16], par_case[i][4], par_case[i][0]);
      bus_rd(3'h5, par_case[i][15:8]);
      bus_rd(3'h0, par_case[i][23:16]);
    end
    bus_wr(3'h1, 8'h07);
    bus_rd(3'h2, 8'h02);
    bus_rd(3'h2, 8'h01);
    rx(8'h33, 1'b0, 1'b0);
    @(negedge mclk);
    chk_byte({7'h00, intrpt}, 8'h01);
    bus_rd(3'h2, 8'h06);
    bus_rd(3'h5, 8'h69);
    bus_rd(3'h2, 8'h04);
    bus_rd(3'h0, 8'h33);
    bus_rd(3'h2, 8'h01);
    bus_wr(3'h1, 8'h08);
    cts_n = 1'b0;
    repeat (3) @(negedge mclk);
    bus_rd(3'h2, 8'h00);
    bus_rd(3'h6, 8'h11);
    bus_rd(3'h2, 8'h01);
    bus_wr(3'h1, 8'h02);
    for (int k = 0; k < 4; k++) begin
      bus_wr(3'h0, 8'ha1 + 8'h11 * 8'(k));
      repeat (3) @(negedge mclk);
    end
    bus_rd(3'h2, 8'h01);
    bus_rd(3'h5, 8'h00);
    n = 0;
    while ((got_count !== 8'h04 || tx_shift_busy !== 1'b0) && n < 400) begin
      @(negedge mclk);
      n++;
    end
    chk_byte(got_count, 8'h04);
    for (int k = 0; k < 4; k++) chk_byte(got_log[31 - 8 * k -: 8], 8'ha1 + 8'h11 * 8'(k));
    bus_rd(3'h2, 8'h02);
    bus_rd(3'h5, 8'h60);
    bus_wr(3'h1, 8'h04);
    sin = 1'b0;
    repeat (600) @(negedge mclk);
    bus_rd(3'h5, 8'h60);
    repeat (1800) @(negedge mclk);
    sin = 1'b1;
    repeat (4) @(negedge mclk);
    bus_rd(3'h2, 8'h06);
    bus_rd(3'h5, 8'h70);
    bus_rd(3'h2, 8'h01);
    report_and_stop();
  end
endmodule
